// File: dmba_pkg.sv
// Functional notes
// - Every access to data memory, extended_data_space included, passes through this arbiter.
// - Exactly three masters may request: the processor core, the DMA controller, the debug module.
// - Coincident requests go to the highest priority; the rest stall until that access completes.
// - By default the core holds priority_slot_0, the highest of five slots.
// - The in_circuit_debug_module always holds priority_slot_4 and wins only when alone.
// - By default the DMA holds priority_slot_3; slots 1 and 2 stay empty.
// - Software writes to bus_master_priority_control raise the DMA above the core or lower it.
// - Raised masters keep their fixed order among themselves, slot 1 highest, slot 3 lowest.
// - Masters left below the core keep their original order among themselves.
// - Value 0x0000 gives core,-,-,DMA,debug; value 0x0020 gives DMA,core,-,-,debug.
// - The order may change at init or at run time and applies to later decisions.
package dmba_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  PRIO_CTRL_OFS  = 8'h58;
    localparam logic [7:0]  STATUS_OFS     = 8'h5C;
    localparam logic [15:0] PRIO_CTRL_RST  = 16'h0000;
    localparam logic [15:0] PRIO_DEFAULT   = 16'h0000;
    localparam logic [15:0] PRIO_DMA_HIGH  = 16'h0020;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int STAT_OWNER_LSB = 0;
    localparam int STAT_BUSY_BIT  = 3;
    localparam int STAT_RAISED_BIT = 4;

    // ------------------------------------------------------------
    // Masters and priority slots
    // ------------------------------------------------------------
    localparam int NUM_MASTERS = 3;
    localparam int SLOT_W      = 3;
    localparam int M_CORE      = 0;
    localparam int M_DMA       = 1;
    localparam int M_DEBUG     = 2;
    localparam logic [2:0] PRIORITY_SLOT_0 = 3'h0;
    localparam logic [2:0] PRIORITY_SLOT_1 = 3'h1;
    localparam logic [2:0] PRIORITY_SLOT_3 = 3'h3;
    localparam logic [2:0] PRIORITY_SLOT_4 = 3'h4;

    // ------------------------------------------------------------
    // Arbiter states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        DMBA_IDLE,
        DMBA_BUSY
    } dmba_state_t;

endpackage

// File: dmba_prio_pick.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Lowest slot number among requesters wins; ties to lower index
// ------------------------------------------------------------
module dmba_prio_pick #(
    parameter int N  = 3,
    parameter int SW = 3
) (
    input  wire logic [N-1:0]    req_i,
    input  wire logic [N*SW-1:0] slot_i,
    output logic      [N-1:0]    win_o
);

    // Elaboration guard
    generate
        if (N < 1 || SW < 1) begin : g_bad_param
            $error("dmba_prio_pick: N and SW must be at least 1");
        end
    endgenerate

    // One comparator chain per candidate; one-hot by construction
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_cand
            logic beaten;
            always_comb begin
                beaten = 1'b0;
                for (int j = 0; j < N; j++) begin
                    if (j != gi && req_i[j]) begin
                        if (slot_i[j*SW +: SW] < slot_i[gi*SW +: SW]) begin
                            beaten = 1'b1;
                        end else if (slot_i[j*SW +: SW] == slot_i[gi*SW +: SW] && j < gi) begin
                            beaten = 1'b1;
                        end
                    end
                end
            end
            assign win_o[gi] = req_i[gi] & ~beaten;
        end
    endgenerate

endmodule

// File: dmba_arbiter.sv
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
// ------------------------------------------------------------
// Data memory bus arbiter with Wishbone register slave
// ------------------------------------------------------------
module dmba_arbiter #(
    parameter int WB_AW  = 8,
    parameter int MEM_AW = 24,
    parameter int MEM_DW = 16
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [WB_AW-1:0]  wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Processor core master
    input  wire logic              core_req_i,
    input  wire logic              core_we_i,
    input  wire logic [MEM_AW-1:0] core_addr_i,
    input  wire logic [MEM_DW-1:0] core_wdata_i,
    output logic                   core_gnt_o,
    output logic                   core_ack_o,
    // DMA controller master
    input  wire logic              dma_req_i,
    input  wire logic              dma_we_i,
    input  wire logic [MEM_AW-1:0] dma_addr_i,
    input  wire logic [MEM_DW-1:0] dma_wdata_i,
    output logic                   dma_gnt_o,
    output logic                   dma_ack_o,
    // Debug module master
    input  wire logic              dbg_req_i,
    input  wire logic              dbg_we_i,
    input  wire logic [MEM_AW-1:0] dbg_addr_i,
    input  wire logic [MEM_DW-1:0] dbg_wdata_i,
    output logic                   dbg_gnt_o,
    output logic                   dbg_ack_o,
    // Shared read data back to masters
    output logic      [MEM_DW-1:0] mst_rdata_o,
    // Data memory side
    output logic                   mem_req_o,
    output logic                   mem_we_o,
    output logic      [MEM_AW-1:0] mem_addr_o,
    output logic      [MEM_DW-1:0] mem_wdata_o,
    input  wire logic              mem_done_i,
    input  wire logic [MEM_DW-1:0] mem_rdata_i
);

    localparam int NM = dmba_pkg::NUM_MASTERS;
    localparam int SW = dmba_pkg::SLOT_W;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (WB_AW < 8) begin : g_bad_aw
            $error("dmba_arbiter: WB_AW must reach the register offsets");
        end
        if (MEM_AW < 1 || MEM_DW < 1) begin : g_bad_mem
            $error("dmba_arbiter: memory widths must be positive");
        end
        if (NM != 3 || SW < 3) begin : g_bad_slots
            $error("dmba_arbiter: three masters and five slots are wired here");
        end
    endgenerate

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Word-aligned register match, shared by read and write decode
    function automatic logic reg_hit(input logic [WB_AW-1:0] adr,
                                     input logic [7:0]       ofs);
        reg_hit = (adr[WB_AW-1:2] == (WB_AW-2)'(ofs[7:2]));
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0]           prio_r;
    logic [15:0]           prio_nxt;
    logic                  wb_ack_r;
    logic                  wb_ack_nxt;
    logic [31:0]           wb_dat_r;
    logic [31:0]           wb_dat_nxt;
    dmba_pkg::dmba_state_t state_r;
    dmba_pkg::dmba_state_t state_nxt;
    logic [NM-1:0]         gnt_r;
    logic [NM-1:0]         gnt_nxt;
    logic [NM-1:0]         last_r;
    logic [NM-1:0]         last_nxt;
    logic [NM-1:0]         ack_r;
    logic [NM-1:0]         ack_nxt;
    logic                  mem_req_r;
    logic                  mem_req_nxt;
    logic                  mem_we_r;
    logic                  mem_we_nxt;
    logic [MEM_AW-1:0]     mem_addr_r;
    logic [MEM_AW-1:0]     mem_addr_nxt;
    logic [MEM_DW-1:0]     mem_wdata_r;
    logic [MEM_DW-1:0]     mem_wdata_nxt;
    logic [MEM_DW-1:0]     rdata_r;
    logic [MEM_DW-1:0]     rdata_nxt;

    logic                  dma_raised;
    logic [NM-1:0]         req_v;
    logic [NM*SW-1:0]      slots;
    logic [NM-1:0]         win;
    logic [NM-1:0]         m_we;
    logic [MEM_AW-1:0]     m_addr  [NM];
    logic [MEM_DW-1:0]     m_wdata [NM];

    // ------------------------------------------------------------
    // Master request bundles, indexed by master number
    // ------------------------------------------------------------
    // Only these three masters reach the memory
    assign req_v[dmba_pkg::M_CORE]    = core_req_i;
    assign req_v[dmba_pkg::M_DMA]     = dma_req_i;
    assign req_v[dmba_pkg::M_DEBUG]   = dbg_req_i;
    assign m_we[dmba_pkg::M_CORE]     = core_we_i;
    assign m_we[dmba_pkg::M_DMA]      = dma_we_i;
    assign m_we[dmba_pkg::M_DEBUG]    = dbg_we_i;
    assign m_addr[dmba_pkg::M_CORE]   = core_addr_i;
    assign m_addr[dmba_pkg::M_DMA]    = dma_addr_i;
    assign m_addr[dmba_pkg::M_DEBUG]  = dbg_addr_i;
    assign m_wdata[dmba_pkg::M_CORE]  = core_wdata_i;
    assign m_wdata[dmba_pkg::M_DMA]   = dma_wdata_i;
    assign m_wdata[dmba_pkg::M_DEBUG] = dbg_wdata_i;

    // ------------------------------------------------------------
    // Priority slot map from the control register
    // ------------------------------------------------------------
    // Anything but the raise value keeps the default order
    // Reserved values still read back exactly as software wrote them
    assign dma_raised = (prio_r == dmba_pkg::PRIO_DMA_HIGH);

    always_comb begin
        slots = '0;
        if (dma_raised) begin
            slots[dmba_pkg::M_DMA*SW +: SW]  = dmba_pkg::PRIORITY_SLOT_0;
            slots[dmba_pkg::M_CORE*SW +: SW] = dmba_pkg::PRIORITY_SLOT_1;
        end else begin
            slots[dmba_pkg::M_CORE*SW +: SW] = dmba_pkg::PRIORITY_SLOT_0;
            slots[dmba_pkg::M_DMA*SW +: SW]  = dmba_pkg::PRIORITY_SLOT_3;
        end
        slots[dmba_pkg::M_DEBUG*SW +: SW] = dmba_pkg::PRIORITY_SLOT_4;
    end

    // ------------------------------------------------------------
    // Winner selection
    // ------------------------------------------------------------
    // Last owner is masked for one cycle while it sees its ack,
    // so it cannot win again before it drops its request
    dmba_prio_pick #(
        .N  (NM),
        .SW (SW)
    ) u_pick (
        .req_i  (req_v & ~last_r),
        .slot_i (slots),
        .win_o  (win)
    );

    // ------------------------------------------------------------
    // Wishbone register slave: next values
    // ------------------------------------------------------------
    // Ack one cycle after the strobe; write lands on the ack edge
    always_comb begin
        prio_nxt   = prio_r;
        wb_dat_nxt = wb_dat_r;
        wb_ack_nxt = wb_cyc_i & wb_stb_i & ~wb_ack_r;
        if (wb_cyc_i && wb_stb_i && wb_ack_r && wb_we_i &&
            reg_hit(wb_adr_i, dmba_pkg::PRIO_CTRL_OFS)) begin
            if (wb_sel_i[0]) begin
                prio_nxt[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                prio_nxt[15:8] = wb_dat_i[15:8];
            end
        end
        // Read data latched at the take edge so it stands with ack
        if (wb_ack_nxt) begin
            wb_dat_nxt = 32'h0000_0000; // Unmapped reads give zero
            if (reg_hit(wb_adr_i, dmba_pkg::PRIO_CTRL_OFS)) begin
                wb_dat_nxt[15:0] = prio_r;
            end else if (reg_hit(wb_adr_i, dmba_pkg::STATUS_OFS)) begin
                wb_dat_nxt[dmba_pkg::STAT_OWNER_LSB +: NM] = gnt_r;
                wb_dat_nxt[dmba_pkg::STAT_BUSY_BIT]         = (state_r == dmba_pkg::DMBA_BUSY);
                wb_dat_nxt[dmba_pkg::STAT_RAISED_BIT]       = dma_raised;
            end
        end
    end

    // Wishbone register slave: registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prio_r   <= dmba_pkg::PRIO_CTRL_RST;
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            prio_r   <= prio_nxt;
            wb_ack_r <= wb_ack_nxt;
            wb_dat_r <= wb_dat_nxt;
        end
    end

    // ------------------------------------------------------------
    // Arbiter sequencing: next values
    // ------------------------------------------------------------
    // Grant is held for the whole access, so losers simply wait;
    // priority is re-read at every decision, never mid-access
    always_comb begin
        state_nxt     = state_r;
        gnt_nxt       = gnt_r;
        last_nxt      = '0;
        ack_nxt       = '0;
        mem_req_nxt   = mem_req_r;
        mem_we_nxt    = mem_we_r;
        mem_addr_nxt  = mem_addr_r;
        mem_wdata_nxt = mem_wdata_r;
        rdata_nxt     = rdata_r;
        case (state_r)
            dmba_pkg::DMBA_IDLE: begin
                if (|win) begin
                    // Lone or winning requester goes straight out
                    state_nxt   = dmba_pkg::DMBA_BUSY;
                    gnt_nxt     = win;
                    mem_req_nxt = 1'b1;
                    for (int i = 0; i < NM; i++) begin
                        if (win[i]) begin
                            mem_we_nxt    = m_we[i];
                            mem_addr_nxt  = m_addr[i];
                            mem_wdata_nxt = m_wdata[i];
                        end
                    end
                end
            end
            dmba_pkg::DMBA_BUSY: begin
                if (mem_done_i) begin
                    // Access complete: release, ack owner, then re-arbitrate
                    state_nxt   = dmba_pkg::DMBA_IDLE;
                    ack_nxt     = gnt_r;
                    last_nxt    = gnt_r;
                    gnt_nxt     = '0;
                    mem_req_nxt = 1'b0;
                    rdata_nxt   = mem_rdata_i;
                end
            end
            default: begin
                state_nxt   = dmba_pkg::DMBA_IDLE;
                gnt_nxt     = '0;
                mem_req_nxt = 1'b0;
            end
        endcase
    end

    // Arbiter sequencing: registers
    // Memory fields keep their last values between accesses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r     <= dmba_pkg::DMBA_IDLE;
            gnt_r       <= '0;
            last_r      <= '0;
            ack_r       <= '0;
            mem_req_r   <= 1'b0;
            mem_we_r    <= 1'b0;
            mem_addr_r  <= '0;
            mem_wdata_r <= '0;
            rdata_r     <= '0;
        end else begin
            state_r     <= state_nxt;
            gnt_r       <= gnt_nxt;
            last_r      <= last_nxt;
            ack_r       <= ack_nxt;
            mem_req_r   <= mem_req_nxt;
            mem_we_r    <= mem_we_nxt;
            mem_addr_r  <= mem_addr_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign wb_ack_o    = wb_ack_r;
    assign wb_dat_o    = wb_dat_r;
    // Grant and ack vectors split back into per-master pins
    assign core_gnt_o  = gnt_r[dmba_pkg::M_CORE];
    assign dma_gnt_o   = gnt_r[dmba_pkg::M_DMA];
    assign dbg_gnt_o   = gnt_r[dmba_pkg::M_DEBUG];
    assign core_ack_o  = ack_r[dmba_pkg::M_CORE];
    assign dma_ack_o   = ack_r[dmba_pkg::M_DMA];
    assign dbg_ack_o   = ack_r[dmba_pkg::M_DEBUG];
    assign mst_rdata_o = rdata_r;
    assign mem_req_o   = mem_req_r;
    assign mem_we_o    = mem_we_r;
    assign mem_addr_o  = mem_addr_r;
    assign mem_wdata_o = mem_wdata_r;

endmodule

// File: dmba_mem_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Data memory model with a latency set per test
// ------------------------------------------------------------
module dmba_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [3:0]  lat_i,
    output logic             done_o,
    output logic      [15:0] rdata_o
);
    logic [3:0]  cnt_r;
    logic [3:0]  cnt_nxt;
    logic [15:0] junk_r;
    logic [15:0] junk_nxt;

    // Wait count, and a read pattern that flips each cycle off the answer
    always_comb begin
        cnt_nxt  = req_i ? cnt_r + 4'h1 : 4'h0;
        junk_nxt = ~junk_r + 16'h1;
    end

    always_ff @(posedge clk_i) begin
        cnt_r  <= rst_i ? 4'h0 : cnt_nxt;
        junk_r <= rst_i ? 16'h1357 : junk_nxt;
    end

    // Zero latency answers in the first request cycle, as real memory may
    assign done_o  = req_i && (cnt_r == lat_i);
    assign rdata_o = done_o ? (addr_i[15:0] ^ 16'h5A3C) : junk_r;
endmodule

// File: dmba_chk_sva.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker for the data memory bus arbiter
// ------------------------------------------------------------
module dmba_chk #(
    parameter int WB_AW  = 8,
    parameter int MEM_AW = 24
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [WB_AW-1:0]  wb_adr_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic              wb_ack_o,
    input wire logic              core_req_i,
    input wire logic              dma_req_i,
    input wire logic              dbg_req_i,
    input wire logic [MEM_AW-1:0] core_addr_i,
    input wire logic              core_gnt_o,
    input wire logic              dma_gnt_o,
    input wire logic              dbg_gnt_o,
    input wire logic              core_ack_o,
    input wire logic              dma_ack_o,
    input wire logic              dbg_ack_o,
    input wire logic              mem_req_o,
    input wire logic [MEM_AW-1:0] mem_addr_o,
    input wire logic              mem_done_i
);
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic        raised;
    logic        wr_hit;
    logic [2:0]  gnt;
    logic [2:0]  ack;

    assign gnt    = {dbg_gnt_o, dma_gnt_o, core_gnt_o};
    assign ack    = {dbg_ack_o, dma_ack_o, core_ack_o};
    assign raised = (ctrl_r == dmba_pkg::PRIO_DMA_HIGH);
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
                    && (wb_adr_i[WB_AW-1:2] == (WB_AW-2)'(dmba_pkg::PRIO_CTRL_OFS[7:2]));

    // Shadow of the control value; lands at the write's ack edge
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_hit && wb_sel_i[0]) ctrl_nxt[7:0] = wb_dat_i[7:0];
        if (wr_hit && wb_sel_i[1]) ctrl_nxt[15:8] = wb_dat_i[15:8];
    end

    always_ff @(posedge clk_i) begin
        ctrl_r <= rst_i ? 16'h0000 : ctrl_nxt;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_wb_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_one_owner: assert property ($onehot0(gnt) && ((|gnt) == mem_req_o))
        else $error("grant not unique or not matched by memory request");
    a_core_lone: assert property (!mem_req_o && core_req_i && !core_ack_o && !dma_req_i
        && !dbg_req_i |=> core_gnt_o) else $error("lone core request not granted at once");
    a_dbg_lone: assert property (!mem_req_o && dbg_req_i && !dbg_ack_o && !dma_req_i
        && !core_req_i |=> dbg_gnt_o) else $error("lone debug request not granted");
    a_prio_order: assert property (!mem_req_o && core_req_i && dma_req_i && !core_ack_o
        && !dma_ack_o |=> ($past(raised) ? dma_gnt_o : core_gnt_o)) else $error("wrong winner");
    a_debug_last: assert property (!mem_req_o && dbg_req_i && ((core_req_i && !core_ack_o)
        || (dma_req_i && !dma_ack_o)) |=> !dbg_gnt_o) else $error("debug beat a master");
    a_ack_follows: assert property (mem_done_i |=> !mem_req_o && (ack == $past(gnt)))
        else $error("completion not acked to owner");
    a_ack_cause: assert property ((|ack) |-> $past(mem_done_i))
        else $error("ack without memory completion");
    a_mem_hold: assert property (mem_req_o && !mem_done_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("memory request changed before completion");
    a_core_route: assert property (core_gnt_o |-> mem_addr_o == core_addr_i)
        else $error("core address not routed");
    a_wb_pulse: assert property (s_wb_take |=> s_ack_pulse)
        else $error("register access not acked for one cycle");
endmodule

bind dmba_arbiter dmba_chk #(.WB_AW(WB_AW), .MEM_AW(MEM_AW)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .core_req_i(core_req_i), .dma_req_i(dma_req_i),
    .dbg_req_i(dbg_req_i), .core_addr_i(core_addr_i), .core_gnt_o(core_gnt_o),
    .dma_gnt_o(dma_gnt_o), .dbg_gnt_o(dbg_gnt_o), .core_ack_o(core_ack_o),
    .dma_ack_o(dma_ack_o), .dbg_ack_o(dbg_ack_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_done_i(mem_done_i)
);

// File: testbench.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Self-checking bench for the data memory bus arbiter
// ------------------------------------------------------------
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wcyc  = 1'b0;
    logic        wstb  = 1'b0;
    logic        wwe   = 1'b0;
    logic [7:0]  wadr  = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic [3:0]  wsel  = 4'h0;
    logic [31:0] wq;
    logic        wack;
    logic [2:0]  req   = 3'h0;
    logic [2:0]  we    = 3'h0;
    logic [23:0] addr [3] = '{default: 24'h0};
    logic [15:0] wdata [3] = '{default: 16'h0};
    logic [2:0]  ack;
    logic [15:0] rdata;
    logic        mreq;
    logic [23:0] madr;
    logic        mdone;
    logic [15:0] mrd;
    logic        mwe;
    logic [15:0] mwd;
    logic [3:0]  lat   = 4'h0;
    logic [5:0]  got;
    logic [31:0] q;
    logic [15:0] cfg [3] = '{16'h0000, 16'h0020, 16'h1234};
    int          fail_count = 0;
    int          checks = 0;

    always #5 clk_i = ~clk_i;

    dmba_arbiter dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wcyc), .wb_stb_i(wstb),
        .wb_we_i(wwe), .wb_adr_i(wadr), .wb_dat_i(wdat), .wb_sel_i(wsel), .wb_dat_o(wq),
        .wb_ack_o(wack), .core_req_i(req[0]), .core_we_i(we[0]), .core_addr_i(addr[0]),
        .core_wdata_i(wdata[0]), .core_gnt_o(), .core_ack_o(ack[0]), .dma_req_i(req[1]),
        .dma_we_i(we[1]), .dma_addr_i(addr[1]), .dma_wdata_i(wdata[1]), .dma_gnt_o(),
        .dma_ack_o(ack[1]), .dbg_req_i(req[2]), .dbg_we_i(we[2]), .dbg_addr_i(addr[2]),
        .dbg_wdata_i(wdata[2]), .dbg_gnt_o(), .dbg_ack_o(ack[2]), .mst_rdata_o(rdata),
        .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(madr), .mem_wdata_o(mwd),
        .mem_done_i(mdone), .mem_rdata_i(mrd));

    dmba_mem_model mdl_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .addr_i(madr),
        .lat_i(lat), .done_o(mdone), .rdata_o(mrd));

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Classic single cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wcyc <= 1'b1;
        wstb <= 1'b1;
        wwe  <= w;
        wadr <= a;
        wdat <= d;
        wsel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (wack !== 1'b1 && n < 50);
        cmp("wb ack", 32'h1, 32'(wack));
        r    = wq;
        wcyc <= 1'b0;
        wstb <= 1'b0;
    endtask

    // One memory word for master m; req held until its ack edge
    task automatic access(input int m);
        int n;
        n = 0;
        @(posedge clk_i);
        req[m] <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack[m] !== 1'b1 && n < 60);
        cmp("master ack", 32'h1, 32'(ack[m]));
        cmp("mem addr", 32'(addr[m]), 32'(madr));
        cmp("mem we", 32'(we[m]), 32'(mwe));
        if (we[m]) cmp("mem wdata", 32'(wdata[m]), 32'(mwd));
        if (!we[m]) cmp("read data", {16'h0, addr[m][15:0] ^ 16'h5A3C}, {16'h0, rdata});
        got    = {got[3:0], m[1:0]};
        req[m] <= 1'b0;
    endtask

    // Service order expected for a set of coincident requesters
    function automatic logic [5:0] exp_order(input logic [2:0] msk, input logic hi);
        logic [5:0] r;
        int         pri [3];
        r = '1;
        if (hi) pri = '{1, 0, 2};
        else pri = '{0, 1, 2};
        for (int i = 0; i < 3; i++) begin
            if (msk[pri[i]]) r = {r[3:0], 2'(pri[i])};
        end
        return r;
    endfunction

    initial begin
        int          c;
        logic [2:0]  msk;
        int          cm [5] = '{7, 7, 7, 6, 4};
        int          cc [5] = '{0, 1, 2, 1, 0};
        void'($urandom(32'hBE2A10AA));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset value, byte lanes and an unmapped place
        wb(1'b0, 8'h58, 32'h0, 4'hF, q);
        cmp("ctrl reset", 32'h0, q);
        wb(1'b1, 8'h58, 32'hFFFF_FFFF, 4'hF, q);
        wb(1'b1, 8'h58, 32'h0, 4'h1, q);
        wb(1'b0, 8'h58, 32'h0, 4'hF, q);
        cmp("ctrl lanes", 32'h0000_FF00, q);
        wb(1'b1, 8'h40, 32'h1234, 4'hF, q);
        wb(1'b0, 8'h40, 32'h0, 4'hF, q);
        cmp("unmapped", 32'h0, q);
        wb(1'b1, 8'h58, 32'h0000_0020, 4'h3, q);
        wb(1'b0, 8'h5C, 32'h0, 4'hF, q);
        cmp("status raised", 32'h1 << dmba_pkg::STAT_RAISED_BIT, q);
        $display("test register done");
        // Corners first, then random requester sets and orders at run time
        for (int t = 0; t < 25; t++) begin
            msk = (t < 5) ? 3'(cm[t]) : 3'($urandom_range(7, 1));
            c   = (t < 5) ? cc[t] : int'($urandom_range(2, 0));
            wb(1'b1, 8'h58, {16'h0, cfg[c]}, 4'h3, q);
            lat <= 4'($urandom_range(5, 0));
            for (int m = 0; m < 3; m++) begin
                we[m]    <= 1'($urandom_range(1, 0));
                addr[m]  <= 24'($urandom);
                wdata[m] <= 16'($urandom);
            end
            got = '1;
            fork
                if (msk[0]) access(0);
                if (msk[1]) access(1);
                if (msk[2]) access(2);
            join
            cmp("grant order", 32'(exp_order(msk, c == 1)), 32'(got));
            $display("test %0d done", t);
        end
        summarize();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        summarize();
    end
endmodule
